// ---- dpz_defs.svh ----
// Timing and encoding constants for the power-down and calibration sequencing link
`ifndef DPZ_DEFS_SVH
`define DPZ_DEFS_SVH

// Timing figures in ns; the clock period is 5 ns
`define DPZ_CLK_PERIOD_NS   5
`define DPZ_TCKE_NS         5
`define DPZ_TXP_NS          6
`define DPZ_TXPDLL_NS       24
`define DPZ_TRFC_NS         160
`define DPZ_TRP_NS          14
`define DPZ_TXS_NS          170
`define DPZ_TZQINIT_NS      2560
`define DPZ_TZQOPER_NS      1280
`define DPZ_TZQCS_NS        320

// Least times round up to whole cycles
`define DPZ_CYC_UP(t) (((t) + `DPZ_CLK_PERIOD_NS - 1) / `DPZ_CLK_PERIOD_NS)
// Longest times round down, never below one cycle
`define DPZ_CYC_DN(t) ((((t) / `DPZ_CLK_PERIOD_NS) < 1) ? 1 : ((t) / `DPZ_CLK_PERIOD_NS))

`define DPZ_TPD_CYC     `DPZ_CYC_UP(`DPZ_TCKE_NS)
`define DPZ_TXP_CYC     `DPZ_CYC_UP(`DPZ_TXP_NS)
`define DPZ_TXPDLL_CYC  `DPZ_CYC_UP(`DPZ_TXPDLL_NS)
`define DPZ_TRFC_CYC    `DPZ_CYC_UP(`DPZ_TRFC_NS)
`define DPZ_TRP_CYC     `DPZ_CYC_UP(`DPZ_TRP_NS)
`define DPZ_TXS_CYC     `DPZ_CYC_UP(`DPZ_TXS_NS)
`define DPZ_TZQINIT_CYC `DPZ_CYC_DN(`DPZ_TZQINIT_NS)
`define DPZ_TZQOPER_CYC `DPZ_CYC_DN(`DPZ_TZQOPER_NS)
`define DPZ_TZQCS_CYC   `DPZ_CYC_DN(`DPZ_TZQCS_NS)
// Short calibration must converge within 64 clocks
`define DPZ_ZQCS_CONV_CYC 64

`define DPZ_CNT_W       10
`define DPZ_CODE_W      6
`define DPZ_CODE_RST    6'h20
`define DPZ_ZQCS_STEP   6'h01

// Command codes
`define DPZ_CMD_NOP     3'h0
`define DPZ_CMD_REF     3'h1
`define DPZ_CMD_PREA    3'h2
`define DPZ_CMD_ZQCL    3'h3
`define DPZ_CMD_ZQCS    3'h4
`define DPZ_CMD_SRE     3'h5
`define DPZ_CMD_ACT     3'h6
`define DPZ_CMD_OTHER   3'h7

`endif

// ---- dpz_pkg.sv ----
// Types shared by both ends of the sequencing link
`default_nettype none
package dpz_pkg;
   typedef logic [2:0] dpz_cmd_t;
   typedef enum logic [5:0] {
      DPZ_C_IDLE = 6'h01,
      DPZ_C_PD   = 6'h02,
      DPZ_C_SR   = 6'h04,
      DPZ_C_ZQ   = 6'h08,
      DPZ_C_WAIT = 6'h10,
      DPZ_C_INIT = 6'h20
   } dpz_ctl_state_t;
   typedef enum logic [3:0] {
      DPZ_D_IDLE = 4'h1,
      DPZ_D_PD   = 4'h2,
      DPZ_D_SR   = 4'h4,
      DPZ_D_CAL  = 4'h8
   } dpz_dev_state_t;
endpackage : dpz_pkg
`default_nettype wire

// ---- dpz_link_if.sv ----
// Command, CKE, ODT and data-bus enable link between controller and device
`timescale 1ns/1ps
`default_nettype none
interface dpz_link_if (input wire logic clock);
   import dpz_pkg::*;
   logic     cke;
   logic     odt;
   dpz_cmd_t cmd;
   logic     ctlDqOe;
   logic     devDqOe;
   logic     calBusy;
   modport ctl (input clock, output cke, output odt, output cmd, output ctlDqOe);
   modport dev (input clock, input cke, input odt, input cmd, input ctlDqOe, output devDqOe,
                output calBusy);
endinterface : dpz_link_if
`default_nettype wire

// ---- dpz_timer.sv ----
// Loadable down-counter that flags expiry
`timescale 1ns/1ps
`default_nettype none
`include "dpz_defs.svh"
module dpz_timer
   import dpz_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  load,
   input  wire logic [`DPZ_CNT_W-1:0] value,
   output logic                       expired
);
   logic [`DPZ_CNT_W-1:0] count_reg;
   logic [`DPZ_CNT_W-1:0] count_next;

   always_comb begin
      count_next = count_reg;
      if (load) begin
         count_next = value;
      end else if (count_reg != '0) begin
         count_next = count_reg - `DPZ_CNT_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   assign expired = (count_reg == '0);
endmodule : dpz_timer
`default_nettype wire

// ---- dpz_device.sv ----
// Device end: power-down tracking and calibration engine
`timescale 1ns/1ps
`default_nettype none
`include "dpz_defs.svh"
module dpz_device
   import dpz_pkg::*;
(
   input  wire logic                   rst,
   dpz_link_if.dev                     link,
   output logic                        inPowerDown,
   output logic                        inSelfRefresh,
   output logic [`DPZ_CODE_W-1:0]      drvCode,
   output logic [`DPZ_CODE_W-1:0]      termCode,
   output logic                        calCurrentOn,
   output logic                        calDone
);
   dpz_dev_state_t            state_reg,    state_next;
   logic                      firstCal_reg, firstCal_next;
   logic [`DPZ_CNT_W-1:0]     cnt_reg,      cnt_next;
   logic [`DPZ_CODE_W-1:0]    drv_reg,      drv_next;
   logic [`DPZ_CODE_W-1:0]    term_reg,     term_next;
   logic                      isLong_reg,   isLong_next;
   logic                      done_reg,     done_next;
   logic                      quiet;

   assign quiet = (link.cmd == `DPZ_CMD_NOP);

   always_comb begin
      state_next    = state_reg;
      firstCal_next = firstCal_reg;
      cnt_next      = cnt_reg;
      drv_next      = drv_reg;
      term_next     = term_reg;
      isLong_next   = isLong_reg;
      done_next     = 1'b0;
      case (state_reg)
         DPZ_D_IDLE: begin
            if (!link.cke && quiet) begin
               state_next = DPZ_D_PD; // RULE1
            end else if (!link.cke && link.cmd == `DPZ_CMD_SRE) begin
               state_next = DPZ_D_SR;
            end else if (link.cke && link.cmd == `DPZ_CMD_ZQCL) begin
               state_next    = DPZ_D_CAL; // RULE8
               isLong_next   = 1'b1;
               firstCal_next = 1'b0;
               cnt_next      = firstCal_reg ? `DPZ_CNT_W'(`DPZ_TZQINIT_CYC)
                                            : `DPZ_CNT_W'(`DPZ_TZQOPER_CYC); // RULE9
            end else if (link.cke && link.cmd == `DPZ_CMD_ZQCS) begin
               state_next  = DPZ_D_CAL; // RULE10
               isLong_next = 1'b0;
               cnt_next    = `DPZ_CNT_W'(`DPZ_ZQCS_CONV_CYC); // RULE11
            end
         end
         DPZ_D_PD: begin
            if (link.cke && quiet) begin
               state_next = DPZ_D_IDLE; // RULE1
            end
         end
         DPZ_D_SR: begin
            // No calibration on exit; codes stay until a command asks
            if (link.cke && quiet) begin
               state_next = DPZ_D_IDLE; // RULE16
            end
         end
         DPZ_D_CAL: begin
            if (cnt_reg > `DPZ_CNT_W'(1)) begin
               cnt_next = cnt_reg - `DPZ_CNT_W'(1);
            end else begin
               // Transfer results to I/O and stop the reference current
               state_next = DPZ_D_IDLE; // RULE14
               done_next  = 1'b1;
               cnt_next   = '0;
               if (isLong_reg) begin
                  drv_next  = `DPZ_CODE_RST; // RULE8
                  term_next = `DPZ_CODE_RST;
               end else begin
                  drv_next  = drv_reg + `DPZ_ZQCS_STEP; // RULE11
                  term_next = term_reg + `DPZ_ZQCS_STEP;
               end
            end
         end
         default: begin
            state_next = DPZ_D_IDLE;
         end
      endcase
   end

   always_ff @(posedge link.clock) begin
      if (rst) begin
         state_reg    <= DPZ_D_IDLE;
         firstCal_reg <= 1'b1;
         cnt_reg      <= '0;
         drv_reg      <= '0;
         term_reg     <= '0;
         isLong_reg   <= 1'b0;
         done_reg     <= 1'b0;
      end else begin
         state_reg    <= state_next;
         firstCal_reg <= firstCal_next;
         cnt_reg      <= cnt_next;
         drv_reg      <= drv_next;
         term_reg     <= term_next;
         isLong_reg   <= isLong_next;
         done_reg     <= done_next;
      end
   end

   assign inPowerDown   = (state_reg == DPZ_D_PD);
   assign inSelfRefresh = (state_reg == DPZ_D_SR);
   assign calCurrentOn  = (state_reg == DPZ_D_CAL); // RULE14
   assign drvCode       = drv_reg;
   assign termCode      = term_reg;
   assign calDone       = done_reg;
   assign link.calBusy  = (state_reg == DPZ_D_CAL);
   // Device never drives DQ in this model; bus is quiet during calibration
   assign link.devDqOe  = 1'b0; // RULE21
endmodule : dpz_device
`default_nettype wire

// ---- dpz_controller.sv ----
// Controller end: sequences power-down, refresh, self-refresh and calibration
//
// Overview of operation
// [RULE1] CKE low with NOP enters, high exits
// [RULE2] Wait tXP, tXPDLL after power-down exit
// [RULE3] Hold CKE low at least tPD
// [RULE4] Refresh after exit waits tXP
// [RULE5] Re-entry waits tXPDLL from exit
// [RULE6] Only NOP until tRFC after refresh
// [RULE7] Long calibration first, allowed any time
// [RULE8] Long calibration updates driver and termination
// [RULE9] First long uses init window, others oper
// [RULE10] Short calibration uses shorter window
// [RULE11] Short step corrects within 64 clocks
// [RULE12] Short interval set by drift rates; code leaves it to the caller's zqsReq pacing
// [RULE13] Channel quiet during calibration windows
// [RULE14] Calibration current off when done
// [RULE15] Precharge all, tRP, before calibration; the initial long calibration after reset is issued with no PREA
// [RULE16] No self-calibration after self-refresh exit
// [RULE17] Calibration no earlier than tXS after exit
// [RULE18] Shared-resistor windows never overlap
// [RULE19] CKE high throughout calibration
// [RULE20] ODT low during calibration
// [RULE21] All DQ drivers off during calibration
// [RULE22] Loadable counters gate conflicting commands
`timescale 1ns/1ps
`default_nettype none
`include "dpz_defs.svh"
module dpz_controller
   import dpz_pkg::*;
(
   input  wire logic  rst,
   dpz_link_if.ctl    link,
   input  wire logic  pdReq,
   input  wire logic  pdExitReq,
   input  wire logic  refReq,
   input  wire logic  srReq,
   input  wire logic  srExitReq,
   input  wire logic  zqlReq,
   input  wire logic  zqsReq,
   input  wire logic  odtReq,
   input  wire logic  zqGrant,
   output logic       zqWinActive,
   output logic       busy
);
   // ---------------------------------------------------------------
   // Timers
   // ---------------------------------------------------------------
   localparam int NT = 6;
   localparam int T_PD = 0;
   localparam int T_XP = 1;
   localparam int T_XPDLL = 2;
   localparam int T_RFC = 3;
   localparam int T_ZQ = 4;
   localparam int T_RP = 5;

   logic [NT-1:0]         tLoad;
   logic [`DPZ_CNT_W-1:0] tVal [NT];
   logic [NT-1:0]         tDone;

   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : gTimer
         dpz_timer uTimer (
            .clock   (link.clock),
            .rst     (rst),
            .load    (tLoad[gi]),
            .value   (tVal[gi]),
            .expired (tDone[gi])
         ); // RULE22
      end
   endgenerate

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   dpz_ctl_state_t        state_reg,   state_next;
   logic                  cke_reg,     cke_next;
   logic                  odt_reg,     odt_next;
   dpz_cmd_t              cmd_reg,     cmd_next;
   logic                  firstZq_reg, firstZq_next;
   logic                  pdAfterRef_reg, pdAfterRef_next;

   always_comb begin
      state_next      = state_reg;
      cke_next        = cke_reg;
      odt_next        = odtReq;
      cmd_next        = `DPZ_CMD_NOP;
      firstZq_next    = firstZq_reg;
      pdAfterRef_next = pdAfterRef_reg;
      tLoad           = '0;
      tVal[T_PD]      = `DPZ_CNT_W'(`DPZ_TPD_CYC);
      tVal[T_XP]      = `DPZ_CNT_W'(`DPZ_TXP_CYC);
      tVal[T_XPDLL]   = `DPZ_CNT_W'(`DPZ_TXPDLL_CYC);
      tVal[T_RFC]     = `DPZ_CNT_W'(`DPZ_TRFC_CYC);
      tVal[T_ZQ]      = `DPZ_CNT_W'(`DPZ_TZQCS_CYC);
      tVal[T_RP]      = `DPZ_CNT_W'(`DPZ_TRP_CYC);
      case (state_reg)
         DPZ_C_INIT: begin
            // Initial long calibration after reset
            if (tDone[T_RP] && zqGrant) begin
               cmd_next     = `DPZ_CMD_ZQCL; // RULE7
               firstZq_next = 1'b0;
               tVal[T_ZQ]   = `DPZ_CNT_W'(`DPZ_TZQINIT_CYC); // RULE9
               tLoad[T_ZQ]  = 1'b1;
               odt_next     = 1'b0;
               state_next   = DPZ_C_ZQ;
            end
         end
         DPZ_C_IDLE: begin
            if ((zqlReq || zqsReq) && zqGrant && tDone[T_RFC] && tDone[T_XP]) begin
               // Precharge all first, then calibrate after tRP
               cmd_next    = `DPZ_CMD_PREA; // RULE15
               tLoad[T_RP] = 1'b1;
               state_next  = DPZ_C_WAIT;
            end else if (refReq && tDone[T_XP] && tDone[T_RFC]) begin
               cmd_next         = `DPZ_CMD_REF; // RULE4
               tLoad[T_RFC]     = 1'b1;
               pdAfterRef_next  = 1'b0;
            end else if (srReq && tDone[T_RFC] && tDone[T_XPDLL]) begin
               cmd_next   = `DPZ_CMD_SRE;
               cke_next   = 1'b0;
               tLoad[T_PD] = 1'b1;
               state_next = DPZ_C_SR;
            end else if (pdReq && tDone[T_XPDLL] && (tDone[T_RFC] || !pdAfterRef_reg)) begin
               // Re-entry gated by tXPDLL; one early entry per refresh
               cke_next        = 1'b0; // RULE5 RULE6 RULE1
               pdAfterRef_next = !tDone[T_RFC];
               tLoad[T_PD]     = 1'b1;
               state_next      = DPZ_C_PD;
            end
         end
         DPZ_C_PD: begin
            if (pdExitReq && tDone[T_PD]) begin
               cke_next       = 1'b1; // RULE3 RULE1
               tLoad[T_XP]    = 1'b1; // RULE2
               tLoad[T_XPDLL] = 1'b1; // RULE5
               state_next     = DPZ_C_IDLE;
            end
         end
         DPZ_C_SR: begin
            if (srExitReq && tDone[T_PD]) begin
               cke_next       = 1'b1;
               tVal[T_XP]     = `DPZ_CNT_W'(`DPZ_TXS_CYC); // RULE17
               tLoad[T_XP]    = 1'b1;
               tVal[T_XPDLL]  = `DPZ_CNT_W'(`DPZ_TXS_CYC);
               tLoad[T_XPDLL] = 1'b1;
               state_next     = DPZ_C_IDLE;
            end
         end
         DPZ_C_WAIT: begin
            odt_next = 1'b0;
            if (tDone[T_RP] && tDone[T_XP]) begin
               cmd_next    = zqlReq ? `DPZ_CMD_ZQCL : `DPZ_CMD_ZQCS; // RULE7 RULE10
               tVal[T_ZQ]  = zqlReq ? (firstZq_reg ? `DPZ_CNT_W'(`DPZ_TZQINIT_CYC)
                                                  : `DPZ_CNT_W'(`DPZ_TZQOPER_CYC))
                                    : `DPZ_CNT_W'(`DPZ_TZQCS_CYC); // RULE9 RULE10
               tLoad[T_ZQ] = 1'b1;
               if (zqlReq) begin
                  firstZq_next = 1'b0;
               end
               state_next  = DPZ_C_ZQ;
            end
         end
         DPZ_C_ZQ: begin
            // Quiet channel, CKE high, ODT low, DQ off
            odt_next = 1'b0; // RULE20
            cke_next = 1'b1; // RULE19
            if (tDone[T_ZQ]) begin
               state_next = DPZ_C_IDLE; // RULE13 RULE18
            end
         end
         default: begin
            state_next = DPZ_C_IDLE;
         end
      endcase
   end

   always_ff @(posedge link.clock) begin
      if (rst) begin
         state_reg      <= DPZ_C_INIT;
         cke_reg        <= 1'b1;
         odt_reg        <= 1'b0;
         cmd_reg        <= `DPZ_CMD_NOP;
         firstZq_reg    <= 1'b1;
         pdAfterRef_reg <= 1'b0;
      end else begin
         state_reg      <= state_next;
         cke_reg        <= cke_next;
         odt_reg        <= odt_next;
         cmd_reg        <= cmd_next;
         firstZq_reg    <= firstZq_next;
         pdAfterRef_reg <= pdAfterRef_next;
      end
   end

   // Interval between short calibrations is the caller's zqsReq pacing
   assign link.cke     = cke_reg;
   assign link.odt     = odt_reg;
   assign link.cmd     = cmd_reg;
   assign link.ctlDqOe = 1'b0; // RULE21
   assign zqWinActive  = (state_reg == DPZ_C_ZQ); // RULE18
   assign busy         = (state_reg != DPZ_C_IDLE); // RULE12
endmodule : dpz_controller
`default_nettype wire

// ---- dpz_link_if_chk.sv ----
// Concurrent checks on the controller-to-device link
`timescale 1ns/1ps
`default_nettype none
`include "dpz_defs.svh"
module dpz_link_if_chk
   import dpz_pkg::*;
(
   input wire logic     clock,
   input wire logic     rst,
   input wire logic     cke,
   input wire logic     odt,
   input wire dpz_cmd_t cmd,
   input wire logic     ctlDqOe,
   input wire logic     devDqOe,
   input wire logic     calBusy
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ----
   // Age counters
   // ----
   localparam logic [9:0] SAT = 10'h3FF;
   logic       ckeDly_reg, ckeDly_next, first_reg, first_next;
   logic [9:0] exitAge_reg, exitAge_next, preaAge_reg, preaAge_next;
   logic [9:0] refAge_reg, refAge_next, busyLen_reg, busyLen_next, win_reg, win_next;
   logic [1:0] falls_reg, falls_next;
   logic       fall;
   assign fall = !cke && ckeDly_reg;
   always_comb begin
      ckeDly_next = cke;
      exitAge_next = (cke && !ckeDly_reg) ? 10'h001 : exitAge_reg + {9'h000, exitAge_reg != SAT};
      preaAge_next = (cmd == `DPZ_CMD_PREA) ? 10'h001 : preaAge_reg + {9'h000, preaAge_reg != SAT};
      refAge_next = (cmd == `DPZ_CMD_REF) ? 10'h001 : refAge_reg + {9'h000, refAge_reg != SAT};
      falls_next = (cmd == `DPZ_CMD_REF) ? 2'h0 : falls_reg + {1'h0, fall && falls_reg != 2'h3};
      busyLen_next = calBusy ? busyLen_reg + 10'h001 : 10'h000;
      first_next = first_reg;
      win_next = win_reg;
      if (cmd == `DPZ_CMD_ZQCS) win_next = 10'(`DPZ_TZQCS_CYC);
      if (cmd == `DPZ_CMD_ZQCL) begin
         win_next = first_reg ? 10'(`DPZ_TZQINIT_CYC) : 10'(`DPZ_TZQOPER_CYC);
         first_next = 1'b0;
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         ckeDly_reg <= 1'b1;
         first_reg <= 1'b1;
         exitAge_reg <= SAT;
         preaAge_reg <= SAT;
         refAge_reg <= SAT;
         falls_reg <= 2'h0;
         busyLen_reg <= 10'h000;
         win_reg <= 10'h000;
      end else begin
         ckeDly_reg <= ckeDly_next;
         first_reg <= first_next;
         exitAge_reg <= exitAge_next;
         preaAge_reg <= preaAge_next;
         refAge_reg <= refAge_next;
         falls_reg <= falls_next;
         busyLen_reg <= busyLen_next;
         win_reg <= win_next;
      end
   end
   // ----
   // Properties
   // ----
   sequence sExit; cke && !ckeDly_reg; endsequence
   sequence sEntry; fall; endsequence
   sequence sZq; cmd == `DPZ_CMD_ZQCL || cmd == `DPZ_CMD_ZQCS; endsequence
   a_exit_with_nop: assert property (sExit |-> cmd == `DPZ_CMD_NOP)
      else $error("power-down exit without NOP");
   a_ref_after_exit: assert property (cmd == `DPZ_CMD_REF |-> exitAge_reg >= `DPZ_TXP_CYC)
      else $error("refresh too soon after exit");
   a_reentry_dll_wait: assert property (sEntry |-> exitAge_reg >= `DPZ_TXPDLL_CYC)
      else $error("re-entry too soon after exit");
   a_single_low_trfc: assert property (sEntry |-> !(refAge_reg < `DPZ_TRFC_CYC && falls_reg != 2'h0))
      else $error("second entry within refresh time");
   a_zq_after_prea: assert property (sZq |-> preaAge_reg >= `DPZ_TRP_CYC)
      else $error("calibration too soon after precharge");
   a_zq_starts_engine: assert property (sZq |-> ##[1:2] calBusy)
      else $error("calibration did not start");
   a_cal_window_len: assert property ($fell(calBusy) |-> busyLen_reg == win_reg)
      else $error("calibration window length wrong");
   a_cal_quiet: assert property (calBusy |-> cmd == `DPZ_CMD_NOP)
      else $error("command during calibration");
   a_cal_cke_high: assert property (calBusy |-> cke)
      else $error("clock enable low during calibration");
   a_cal_odt_low: assert property (calBusy |-> !odt)
      else $error("termination on during calibration");
   a_dq_released: assert property (calBusy |-> !ctlDqOe && !devDqOe)
      else $error("data driver on during calibration");
endmodule : dpz_link_if_chk
`default_nettype wire

// ---- tb_dram_powerdown_zq_calibration_sequencing.sv ----
// Bench joining controller and device across the link
`timescale 1ns/1ps
`default_nettype none
`include "dpz_defs.svh"
module tb_dram_powerdown_zq_calibration_sequencing;
   logic clock, rst, pdReq, pdExitReq, refReq, srReq, srExitReq, zqlReq, zqsReq, odtReq, zqGrant;
   logic zqWinActive, busy, inPowerDown, inSelfRefresh, calCurrentOn, calDone, ckePrev;
   logic [`DPZ_CODE_W-1:0] drvCode, termCode;
   logic [2:0] lastZq;
   int failures = 0, cmp_count = 0, cyc = 0, nRef = 0, nZq = 0, nFall = 0, nRise = 0, nDone = 0;
   int calLen, tRef, tZq, tPrea, tFall, tRise;
   wire [2:0] cmd = dpz_link_if_i.cmd;
   wire       cke = dpz_link_if_i.cke;
   dpz_link_if dpz_link_if_i (.clock(clock));
   dpz_controller dpz_controller_i (.rst(rst), .link(dpz_link_if_i), .pdReq(pdReq),
      .pdExitReq(pdExitReq), .refReq(refReq), .srReq(srReq), .srExitReq(srExitReq),
      .zqlReq(zqlReq), .zqsReq(zqsReq), .odtReq(odtReq), .zqGrant(zqGrant),
      .zqWinActive(zqWinActive), .busy(busy));
   dpz_device dpz_device_i (.rst(rst), .link(dpz_link_if_i), .inPowerDown(inPowerDown),
      .inSelfRefresh(inSelfRefresh), .drvCode(drvCode), .termCode(termCode),
      .calCurrentOn(calCurrentOn), .calDone(calDone));
   dpz_link_if_chk dpz_link_if_chk_i (.clock(clock), .rst(rst), .cke(dpz_link_if_i.cke),
      .odt(dpz_link_if_i.odt), .cmd(dpz_link_if_i.cmd), .ctlDqOe(dpz_link_if_i.ctlDqOe),
      .devDqOe(dpz_link_if_i.devDqOe), .calBusy(dpz_link_if_i.calBusy));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // ----
   // Link monitor
   // ----
   always @(posedge clock) begin
      cyc++;
      if (!rst) begin
         if (cmd === `DPZ_CMD_REF) begin
            nRef++;
            tRef = cyc;
         end
         if (cmd === `DPZ_CMD_PREA) tPrea = cyc;
         if (cmd === `DPZ_CMD_ZQCL || cmd === `DPZ_CMD_ZQCS) begin
            nZq++;
            tZq = cyc;
            lastZq = cmd;
            calLen = 0;
         end
         if (calCurrentOn === 1'b1) calLen++;
         if (calDone === 1'b1) nDone++;
         if (ckePrev === 1'b1 && cke === 1'b0) begin
            nFall++;
            tFall = cyc;
         end
         if (ckePrev === 1'b0 && cke === 1'b1) begin
            nRise++;
            tRise = cyc;
         end
      end
      ckePrev = cke;
   end
   always @(posedge clock) begin
      if (cyc == 5000) begin
         failures++;
         conclude();
      end
   end
   // ----
   // Shared tasks
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   task automatic waitEv(ref int c, input int b);
      int k;
      k = 0;
      while (c == b && k < 1000) begin
         step(1);
         k++;
      end
      check(c != b, 1'b1);
   endtask : waitEv
   task automatic reqZq(input logic lng);
      int b;
      b = nZq;
      if (lng) zqlReq = 1'b1;
      else zqsReq = 1'b1;
      waitEv(nZq, b);
      {zqlReq, zqsReq} = 2'h0;
      b = nDone;
      waitEv(nDone, b);
      step(2);
   endtask : reqZq
   task automatic conclude();
      if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   // ----
   // Scenarios
   // ----
   task automatic initCal();
      waitEv(nDone, 0);
      step(2);
      check(lastZq, `DPZ_CMD_ZQCL);
      check(calLen, `DPZ_TZQINIT_CYC);
      check(drvCode, `DPZ_CODE_RST);
      check(termCode, `DPZ_CODE_RST);
      check(calCurrentOn, 1'b0);
      check(calDone, 1'b0);
      check(busy, 1'b0);
   endtask : initCal
   task automatic shortCal();
      odtReq = 1'b1;
      reqZq(1'b0);
      check(tZq - tPrea >= `DPZ_TRP_CYC, 1'b1);
      check(lastZq, `DPZ_CMD_ZQCS);
      check(calLen, `DPZ_TZQCS_CYC);
      check(termCode, 6'h21);
      check(drvCode, 6'h21);
   endtask : shortCal
   task automatic longCal();
      reqZq(1'b1);
      check(calLen, `DPZ_TZQOPER_CYC);
      check(termCode, `DPZ_CODE_RST);
   endtask : longCal
   task automatic grantHold();
      int b;
      b = nZq;
      zqGrant = 1'b0;
      zqsReq = 1'b1;
      step(100);
      check(nZq, b);
      check(zqWinActive, 1'b0);
      zqGrant = 1'b1;
      waitEv(nZq, b);
      zqsReq = 1'b0;
      check(zqWinActive, 1'b1);
      check(busy, 1'b1);
      b = nDone;
      waitEv(nDone, b);
      step(2);
   endtask : grantHold
   task automatic pdSeq();
      int b;
      b = nFall;
      pdReq = 1'b1;
      waitEv(nFall, b);
      pdReq = 1'b0;
      step(2);
      check(inPowerDown, 1'b1);
      b = nRise;
      pdExitReq = 1'b1;
      waitEv(nRise, b);
      pdExitReq = 1'b0;
      check(tRise - tFall >= `DPZ_TPD_CYC, 1'b1);
      b = nRef;
      {refReq, pdReq} = 2'h3;
      waitEv(nRef, b);
      refReq = 1'b0;
      check(tRef - tRise >= `DPZ_TXP_CYC, 1'b1);
      b = nFall;
      waitEv(nFall, b);
      pdReq = 1'b0;
      check(tFall - tRise >= `DPZ_TXPDLL_CYC, 1'b1);
      b = nRise;
      pdExitReq = 1'b1;
      waitEv(nRise, b);
      pdExitReq = 1'b0;
      b = nFall;
      pdReq = 1'b1;
      waitEv(nFall, b);
      pdReq = 1'b0;
      check(tFall - tRef >= `DPZ_TRFC_CYC, 1'b1);
      b = nRise;
      pdExitReq = 1'b1;
      waitEv(nRise, b);
      pdExitReq = 1'b0;
      step(2);
      check(inPowerDown, 1'b0);
   endtask : pdSeq
   task automatic srSeq();
      int b;
      logic [`DPZ_CODE_W-1:0] code;
      code = termCode;
      b = nFall;
      srReq = 1'b1;
      waitEv(nFall, b);
      srReq = 1'b0;
      step(2);
      check(inSelfRefresh, 1'b1);
      b = nRise;
      srExitReq = 1'b1;
      waitEv(nRise, b);
      srExitReq = 1'b0;
      step(20);
      check(termCode, code);
      check(calCurrentOn, 1'b0);
      reqZq(1'b0);
      check(tZq - tRise >= `DPZ_TXS_CYC, 1'b1);
      check(termCode, code + 6'h01);
   endtask : srSeq
   initial begin
      rst = 1'b1;
      zqGrant = 1'b1;
      {pdReq, pdExitReq, refReq, srReq, srExitReq, zqlReq, zqsReq, odtReq} = 8'h00;
      step(5);
      rst = 1'b0;
      initCal();
      shortCal();
      longCal();
      grantHold();
      pdSeq();
      srSeq();
      conclude();
   end
endmodule : tb_dram_powerdown_zq_calibration_sequencing
`default_nettype wire
